// File: dram_mode_one_pkg.sv
// Constants, field layout and decode functions for mode register one
`default_nettype none
package dram_mode_one_pkg;

   // Register size and value after reset
   localparam int MR_WIDTH = 17;
   localparam logic [16:0] MR_RESET_VALUE = 17'h00000;

   // Field positions inside mode register one
   localparam int DLL_OFF_BIT = 0;
   localparam int DRIVE_LO_BIT = 1;
   localparam int TERM_LO_BIT = 2;
   localparam int POSTED_LO_BIT = 3;
   localparam int POSTED_HI_BIT = 4;
   localparam int DRIVE_HI_BIT = 5;
   localparam int TERM_MID_BIT = 6;
   localparam int LEVELING_BIT = 7;
   localparam int TERM_HI_BIT = 9;
   localparam int STROBE_PAIR_BIT = 11;
   localparam int OUTPUT_OFF_BIT = 12;

   // Delay line depth for held commands; posted latency tops out below it
   localparam int HOLD_DEPTH = 16;
   localparam logic [3:0] LATENCY_SIX = 4'h6;

   // Posted latency selections
   typedef enum logic [1:0]
   {
      POSTED_ZERO = 2'h0,
      POSTED_MINUS_ONE = 2'h1,
      POSTED_MINUS_TWO = 2'h2,
      POSTED_RESERVED = 2'h3
   } posted_mode_t;

   // Loop control states, Gray coded along off -> on -> self refresh
   typedef enum logic [1:0]
   {
      DLL_OFF = 2'h0,
      DLL_ON = 2'h1,
      DLL_SUSPENDED = 2'h3
   } dll_state_t;

   // Nominal termination code to resistor divisor, zero means off
   function automatic logic [3:0] nominal_divisor(input logic [2:0] code);
      case (code)
         3'h1: nominal_divisor = 4'h4;
         3'h2: nominal_divisor = 4'h2;
         3'h3: nominal_divisor = 4'h6;
         3'h4: nominal_divisor = 4'hc;
         3'h5: nominal_divisor = 4'h8;
         default: nominal_divisor = 4'h0;
      endcase
   endfunction

   // Write termination code to resistor divisor, zero means off
   function automatic logic [3:0] write_divisor(input logic [1:0] code);
      case (code)
         2'h1: write_divisor = 4'h4;
         2'h2: write_divisor = 4'h2;
         default: write_divisor = 4'h0;
      endcase
   endfunction

endpackage
`default_nettype wire

// File: command_hold.sv
// Delay line that holds read and write commands for the posted latency
`timescale 1ns/100ps
`default_nettype none
module command_hold
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic read_cmd,
   input wire logic write_cmd,
   input wire logic [3:0] hold_cycles,
   output logic read_release,
   output logic write_release
);
   import dram_mode_one_pkg::*;

   logic [1:0] hold_reg [HOLD_DEPTH];

   // Shift commands down the line every cycle
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < HOLD_DEPTH; i++)
            hold_reg[i] <= 2'h0;
      end
      else
      begin
         hold_reg[0] <= {write_cmd, read_cmd};
         for (int i = 1; i < HOLD_DEPTH; i++)
            hold_reg[i] <= hold_reg[i-1];
      end
   end

   // Tap selected by latency; release one cycle plus the held time
   assign read_release = hold_reg[hold_cycles][0];
   assign write_release = hold_reg[hold_cycles][1];

   hold_six_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (read_cmd && hold_cycles == 4'h6) ##1 (hold_cycles == 4'h6)[*7]
      |-> read_release)
      else $error("read not released after posted latency of six");

   hold_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (write_cmd && hold_cycles == 4'h0) ##1 (hold_cycles == 4'h0)
      |-> write_release)
      else $error("write not released one cycle after command");

endmodule
`default_nettype wire

// File: termination_select.sv
// Chooses the termination divisor from nominal, write and leveling state
`timescale 1ns/100ps
`default_nettype none
module termination_select
(
   input wire logic [2:0] nominal_code,
   input wire logic [1:0] write_code,
   input wire logic leveling_on,
   input wire logic outputs_off,
   input wire logic write_active,
   output logic [3:0] divisor
);
   import dram_mode_one_pkg::*;

   logic [3:0] nominal_value;
   logic [3:0] write_value;
   logic nominal_is_write_value;
   logic nominal_allowed;
   logic [3:0] nominal_gated;

   // Decode both selections through the shared tables
   assign nominal_value = nominal_divisor(nominal_code);
   assign write_value = write_divisor(write_code);

   // Leveling with outputs live keeps only values usable for writes
   assign nominal_is_write_value = (nominal_value == 4'h2) ||
      (nominal_value == 4'h4);
   assign nominal_allowed = !leveling_on || outputs_off ||
      nominal_is_write_value;
   assign nominal_gated = nominal_allowed ? nominal_value : 4'h0;

   // A nonzero dynamic write value overrides the nominal one during writes
   assign divisor = (write_active && write_value != 4'h0) ?
      write_value : nominal_gated;

endmodule
`default_nettype wire

// File: dram_mode_register_one.sv
// Mode register one of the memory device and the behaviour it selects
`timescale 1ns/100ps
`default_nettype none
module dram_mode_register_one
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic mode_load,
   input wire logic [16:0] mode_load_data,
   input wire logic dll_reset_cmd,
   input wire logic self_refresh_enter,
   input wire logic self_refresh_exit,
   input wire logic zq_calibrate_cmd,
   input wire logic termination_control_pin,
   input wire logic read_cmd,
   input wire logic write_cmd,
   input wire logic write_active,
   input wire logic data_drive_request,
   input wire logic by8_config,
   input wire logic [3:0] read_column_latency,
   input wire logic [3:0] write_column_latency,
   input wire logic [1:0] write_termination_value,
   output logic [16:0] mode_register_one,
   output logic dll_locked,
   output logic dll_reset_out,
   output logic dll_off_latency_ok,
   output logic [3:0] drive_divisor,
   output logic impedance_calibrated,
   output logic dq_output_enable,
   output logic write_leveling_mode,
   output logic termination_strobe_pair_enable,
   output logic termination_strobe_pair_oe,
   output logic write_mask_enable,
   output logic termination_on,
   output logic [3:0] nominal_termination_value,
   output logic [3:0] posted_latency,
   output logic [4:0] total_read_latency,
   output logic [4:0] total_write_latency,
   output logic read_release,
   output logic write_release
);
   import dram_mode_one_pkg::*;

   logic [16:0] mode_reg;
   dll_state_t dll_state_reg;
   dll_state_t dll_state_next;
   logic dll_reset_reg;
   logic dll_reset_next;
   logic self_refresh_reg;
   logic calibrated_reg;
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic [3:0] drive_reg;
   logic dq_oe_reg;
   logic term_on_reg;
   logic [3:0] term_div_reg;
   logic [3:0] posted_reg;
   logic [4:0] read_lat_reg;
   logic [4:0] write_lat_reg;
   logic lat_ok_reg;

   logic loop_enabled;
   logic [2:0] nominal_code;
   logic [1:0] drive_code;
   posted_mode_t posted_mode;
   logic leveling_on;
   logic outputs_off;
   logic strobe_pair_on;
   logic [3:0] selected_divisor;
   logic [3:0] posted_next;
   logic [3:0] drive_next;
   logic term_allowed;

   // Field extraction; reserved bits are stored but steer nothing
   assign loop_enabled = !mode_reg[DLL_OFF_BIT];
   assign nominal_code = {mode_reg[TERM_HI_BIT], mode_reg[TERM_MID_BIT],
      mode_reg[TERM_LO_BIT]};
   assign drive_code = {mode_reg[DRIVE_HI_BIT], mode_reg[DRIVE_LO_BIT]};
   assign posted_mode = posted_mode_t'(mode_reg[POSTED_HI_BIT:POSTED_LO_BIT]);
   assign leveling_on = mode_reg[LEVELING_BIT];
   assign outputs_off = mode_reg[OUTPUT_OFF_BIT];
   // The pair exists only on by-eight parts, so other widths ignore it
   assign strobe_pair_on = mode_reg[STROBE_PAIR_BIT] && by8_config;

   // Mode load stores the whole word; only reset or a new load changes it
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         mode_reg <= MR_RESET_VALUE;
      else if (mode_load)
         mode_reg <= mode_load_data;
   end

   // Loop control: self refresh suspends a running loop only
   always_comb
   begin
      dll_state_next = dll_state_reg;
      dll_reset_next = 1'b0;
      case (dll_state_reg)
         DLL_OFF:
         begin
            // A stopped loop restarts only on enable plus reset
            if (loop_enabled && dll_reset_cmd && !self_refresh_reg)
            begin
               dll_state_next = DLL_ON;
               dll_reset_next = 1'b1;
            end
         end
         DLL_ON:
         begin
            if (!loop_enabled)
               dll_state_next = DLL_OFF;
            else if (self_refresh_enter)
               dll_state_next = DLL_SUSPENDED;
            else if (dll_reset_cmd)
               dll_reset_next = 1'b1;
         end
         DLL_SUSPENDED:
         begin
            // Automatic restart with its own reset on exit
            if (self_refresh_exit)
            begin
               dll_state_next = DLL_ON;
               dll_reset_next = 1'b1;
            end
         end
         default:
            dll_state_next = DLL_OFF;
      endcase
   end

   // Loop state, reset pulse and self refresh flag
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         dll_state_reg <= DLL_OFF;
         dll_reset_reg <= 1'b0;
         self_refresh_reg <= 1'b0;
      end
      else
      begin
         dll_state_reg <= dll_state_next;
         dll_reset_reg <= dll_reset_next;
         // Enter wins over exit if both arrive together
         if (self_refresh_enter)
            self_refresh_reg <= 1'b1;
         else if (self_refresh_exit)
            self_refresh_reg <= 1'b0;
      end
   end

   // Calibration flag is sticky; later commands leave the drive code alone
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         calibrated_reg <= 1'b0;
      else if (zq_calibrate_cmd)
         calibrated_reg <= 1'b1;
   end

   // Termination pin comes from the board, so it is synchronised first
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= termination_control_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Divisor choice with leveling limits and dynamic write override
   termination_select u_termination_select
   (
      .nominal_code(nominal_code),
      .write_code(write_termination_value),
      .leveling_on(leveling_on),
      .outputs_off(outputs_off),
      .write_active(write_active),
      .divisor(selected_divisor)
   );

   // Termination needs a running loop and is idle in self refresh
   assign term_allowed = (dll_state_reg == DLL_ON) &&
      !self_refresh_reg && (selected_divisor != 4'h0);

   // Drive impedance: six-way is the primary setting (code zero), seven-way code one, other codes zero
   assign drive_next = (drive_code == 2'h1) ? 4'h7 :
      ((drive_code == 2'h0) ? 4'h6 : 4'h0);

   // Posted latency from the read column latency; reserved means zero
   always_comb
   begin
      case (posted_mode)
         POSTED_MINUS_ONE: posted_next = read_column_latency - 4'h1;
         POSTED_MINUS_TWO: posted_next = read_column_latency - 4'h2;
         default: posted_next = 4'h0;
      endcase
   end

   // Registered views of the selected behaviour
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         drive_reg <= 4'h0;
         dq_oe_reg <= 1'b0;
         term_on_reg <= 1'b0;
         term_div_reg <= 4'h0;
         posted_reg <= 4'h0;
         read_lat_reg <= 5'h00;
         write_lat_reg <= 5'h00;
         lat_ok_reg <= 1'b0;
      end
      else
      begin
         drive_reg <= drive_next;
         dq_oe_reg <= data_drive_request && !outputs_off;
         term_on_reg <= pin_sync_reg && term_allowed;
         term_div_reg <= selected_divisor;
         posted_reg <= posted_next;
         read_lat_reg <= {1'b0, posted_next} +
            {1'b0, read_column_latency};
         write_lat_reg <= {1'b0, posted_next} +
            {1'b0, write_column_latency};
         // With the loop off only latency six is usable
         lat_ok_reg <= (dll_state_reg == DLL_ON) ||
            (read_column_latency == LATENCY_SIX &&
            write_column_latency == LATENCY_SIX);
      end
   end

   // Read and write commands wait out the posted latency
   command_hold u_command_hold
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .read_cmd(read_cmd),
      .write_cmd(write_cmd),
      .hold_cycles(posted_reg),
      .read_release(read_release),
      .write_release(write_release)
   );

   // Output assignments
   assign mode_register_one = mode_reg;
   assign dll_locked = (dll_state_reg == DLL_ON);
   assign dll_reset_out = dll_reset_reg;
   assign dll_off_latency_ok = lat_ok_reg;
   assign drive_divisor = drive_reg;
   assign impedance_calibrated = calibrated_reg;
   assign dq_output_enable = dq_oe_reg;
   assign write_leveling_mode = leveling_on;
   assign termination_strobe_pair_enable = strobe_pair_on
      && term_on_reg;
   // The pair is termination only; it never drives
   assign termination_strobe_pair_oe = 1'b0;
   assign write_mask_enable = !strobe_pair_on;
   assign termination_on = term_on_reg;
   assign nominal_termination_value = term_div_reg;
   assign posted_latency = posted_reg;
   assign total_read_latency = read_lat_reg;
   assign total_write_latency = write_lat_reg;

   load_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_load ##1 !mode_load [*2] |->
      mode_register_one == $past(mode_load_data, 2))
      else $error("register lost its loaded value");

   output_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(outputs_off) |-> !dq_output_enable)
      else $error("data driven while outputs are disabled");

   mask_share_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_register_one[STROBE_PAIR_BIT] && by8_config
      |-> !write_mask_enable && !termination_strobe_pair_oe)
      else $error("write mask active with strobe pair enabled");

   sr_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dll_state_reg == DLL_SUSPENDED && self_refresh_exit
      |=> dll_locked && dll_reset_out)
      else $error("loop not restarted and reset on self refresh exit");

   sr_stays_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dll_state_reg == DLL_OFF && !dll_reset_cmd |=> !dll_locked)
      else $error("stopped loop restarted without a reset command");

   no_term_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(!dll_locked) |-> !termination_on)
      else $error("termination on while loop is off");

   level_term_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(leveling_on && !outputs_off && !write_active)
      && nominal_termination_value != 4'h0
      |-> nominal_termination_value inside {4'h2, 4'h4})
      else $error("leveling allowed a non-write termination value");

   read_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $stable(read_column_latency) && $stable(posted_mode)
      |=> total_read_latency == {1'b0, posted_latency} +
      {1'b0, $past(read_column_latency)})
      else $error("read latency is not posted plus column latency");

endmodule
`default_nettype wire

// File: mode_load_driver.sv
// Memory controller model that issues mode-load and loop reset commands
`timescale 1ns/100ps
`default_nettype none
module mode_load_driver
(
   input wire logic clk_sys,
   input wire logic by8_config,
   output logic mode_load,
   output logic [16:0] mode_load_data,
   output logic dll_reset_cmd
);
   // Reserved positions sixteen, thirteen, ten and eight
   localparam logic [16:0] RESERVED_MASK = 17'h12500;

   // Idle command lines at time zero
   initial
   begin
      mode_load = 1'b0;
      mode_load_data = 17'h00000;
      dll_reset_cmd = 1'b0;
   end

   // One load; callers only use it with no access in flight
   task automatic load_word(input logic [16:0] word);
      begin
         mode_load_data = word & ~RESERVED_MASK;
         // Strobe pair only ever requested on by-eight parts
         if (!by8_config)
            mode_load_data[11] = 1'b0;
         mode_load = 1'b1;
         @(posedge clk_sys);
         #1;
         mode_load = 1'b0;
         // Released bus toggles so stale data is never mistaken for valid
         mode_load_data = ~mode_load_data;
         repeat (2) @(posedge clk_sys);
         #1;
      end
   endtask

   // Loop enable is always chased by its own reset command
   task automatic enable_loop(input logic [16:0] word);
      begin
         load_word(word & 17'h1fffe);
         dll_reset_cmd = 1'b1;
         @(posedge clk_sys);
         #1;
         dll_reset_cmd = 1'b0;
         @(posedge clk_sys);
         #1;
      end
   endtask
endmodule
`default_nettype wire

// File: dram_mode_register_one_tb.sv
// Self-checking bench for mode register one and its selected behaviour
`timescale 1ns/100ps
`default_nettype none
module dram_mode_register_one_tb;
   import dram_mode_one_pkg::*;

   localparam logic [3:0] NOM_DIV [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc,
      4'h8, 4'h0, 4'h0};
   localparam logic [2:0] LV_CODE [4] = '{3'h3, 3'h3, 3'h2, 3'h5};
   localparam logic [3:0] LV_EXP [4] = '{4'h0, 4'h6, 4'h2, 4'h8};
   localparam logic [3:0] AL_EXP [4] = '{4'h0, 4'h6, 4'h5, 4'h0};

   logic clk_sys, rst_n, mode_load, dll_reset_cmd, self_refresh_enter;
   logic self_refresh_exit, zq_calibrate_cmd, termination_control_pin;
   logic read_cmd, write_cmd, write_active, data_drive_request, by8_config;
   logic [16:0] mode_load_data, mode_register_one, w;
   logic [3:0] read_column_latency, write_column_latency;
   logic [1:0] write_termination_value;
   logic dll_locked, dll_reset_out, dll_off_latency_ok, impedance_calibrated;
   logic dq_output_enable, write_leveling_mode, write_mask_enable;
   logic termination_strobe_pair_enable, termination_strobe_pair_oe;
   logic termination_on, read_release, write_release;
   logic [3:0] drive_divisor, nominal_termination_value, posted_latency;
   logic [4:0] total_read_latency, total_write_latency;
   int err_total, samples_checked, k;

   mode_load_driver ctrl (.clk_sys(clk_sys), .by8_config(by8_config),
      .mode_load(mode_load), .mode_load_data(mode_load_data),
      .dll_reset_cmd(dll_reset_cmd));

   dram_mode_register_one uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .mode_load(mode_load), .mode_load_data(mode_load_data),
      .dll_reset_cmd(dll_reset_cmd), .self_refresh_enter(self_refresh_enter),
      .self_refresh_exit(self_refresh_exit),
      .zq_calibrate_cmd(zq_calibrate_cmd),
      .termination_control_pin(termination_control_pin),
      .read_cmd(read_cmd), .write_cmd(write_cmd),
      .write_active(write_active), .data_drive_request(data_drive_request),
      .by8_config(by8_config), .read_column_latency(read_column_latency),
      .write_column_latency(write_column_latency),
      .write_termination_value(write_termination_value),
      .mode_register_one(mode_register_one), .dll_locked(dll_locked),
      .dll_reset_out(dll_reset_out), .dll_off_latency_ok(dll_off_latency_ok),
      .drive_divisor(drive_divisor),
      .impedance_calibrated(impedance_calibrated),
      .dq_output_enable(dq_output_enable),
      .write_leveling_mode(write_leveling_mode),
      .termination_strobe_pair_enable(termination_strobe_pair_enable),
      .termination_strobe_pair_oe(termination_strobe_pair_oe),
      .write_mask_enable(write_mask_enable), .termination_on(termination_on),
      .nominal_termination_value(nominal_termination_value),
      .posted_latency(posted_latency),
      .total_read_latency(total_read_latency),
      .total_write_latency(total_write_latency),
      .read_release(read_release), .write_release(write_release));

   // Free-running clock, 8 ns period
   always #4 clk_sys = ~clk_sys;

   // Inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask

   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      begin
         samples_checked++;
         if (got !== exp)
         begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Termination code scattered over bits nine, six and two
   function automatic logic [16:0] nom_word(input logic [2:0] c);
      nom_word = (17'(c[2]) << 9) | (17'(c[1]) << 6) | (17'(c[0]) << 2);
   endfunction

   task automatic sr_pulse(input logic ent);
      begin
         self_refresh_enter = ent;
         self_refresh_exit = ~ent;
         // Termination is switched off for the whole self refresh stay
         termination_control_pin = ~ent;
         step(1);
         self_refresh_enter = 1'b0;
         self_refresh_exit = 1'b0;
      end
   endtask

   task automatic test_done;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      #100000;
      err_total++;
      $display("watchdog expired");
      test_done();
   end

   // Main sequence
   initial
   begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      {self_refresh_enter, self_refresh_exit, zq_calibrate_cmd} = 3'h0;
      {read_cmd, write_cmd, write_active, by8_config} = 4'h0;
      termination_control_pin = 1'b1;
      data_drive_request = 1'b1;
      read_column_latency = 4'h7;
      write_column_latency = 4'h6;
      write_termination_value = 2'h0;
      err_total = 0;
      samples_checked = 0;
      step(2);
      rst_n = 1'b1;
      step(1);
      chk(mode_register_one, 17'h00000);
      chk(17'(write_mask_enable), 17'h1);
      chk(17'(impedance_calibrated), 17'h0);
      $display("test reset done");
      ctrl.enable_loop(17'h00000);
      chk(17'(dll_locked), 17'h1);
      for (int i = 0; i < 8; i++)
      begin
         w = nom_word(i[2:0]) | (17'(i[0]) << 1);
         ctrl.load_word(w);
         step(2);
         chk(mode_register_one, w);
         chk(17'(nominal_termination_value), 17'(NOM_DIV[i]));
         chk(17'(drive_divisor), i[0] ? 17'h7 : 17'h6);
         chk(17'(termination_on), 17'(NOM_DIV[i] != 4'h0));
      end
      $display("test drive and termination done");
      for (int i = 0; i < 4; i++)
      begin
         ctrl.load_word(nom_word(LV_CODE[i]) | 17'h80 | (17'(i[0]) << 12));
         step(2);
         chk(17'(nominal_termination_value), 17'(LV_EXP[i]));
         chk(17'(write_leveling_mode), 17'h1);
         chk(17'(dq_output_enable), 17'(!i[0]));
      end
      $display("test leveling done");
      ctrl.load_word(nom_word(3'h1));
      write_active = 1'b1;
      write_termination_value = 2'h2;
      step(2);
      chk(17'(nominal_termination_value), 17'h2);
      write_termination_value = 2'h3;
      step(2);
      chk(17'(nominal_termination_value), 17'h4);
      write_active = 1'b0;
      termination_control_pin = 1'b0;
      step(3);
      chk(17'(termination_on), 17'h0);
      termination_control_pin = 1'b1;
      step(3);
      chk(17'(termination_on), 17'h1);
      data_drive_request = 1'b0;
      step(2);
      chk(17'(dq_output_enable), 17'h0);
      data_drive_request = 1'b1;
      $display("test dynamic termination done");
      by8_config = 1'b1;
      ctrl.load_word(nom_word(3'h1) | 17'h00800);
      step(2);
      chk(17'(write_mask_enable), 17'h0);
      chk(17'(termination_strobe_pair_enable), 17'h1);
      chk(17'(termination_strobe_pair_oe), 17'h0);
      by8_config = 1'b0;
      ctrl.load_word(nom_word(3'h1) | 17'h00800);
      step(2);
      chk(17'(write_mask_enable), 17'h1);
      chk(17'(termination_strobe_pair_enable), 17'h0);
      $display("test strobe pair done");
      for (int i = 0; i < 4; i++)
      begin
         ctrl.load_word(17'(i) << 3);
         step(1);
         chk(17'(posted_latency), 17'(AL_EXP[i]));
         chk(17'(total_read_latency), 17'(AL_EXP[i]) + 17'h7);
         chk(17'(total_write_latency), 17'(AL_EXP[i]) + 17'h6);
         // Nominal field is off here, so reads meet no termination
         read_cmd = 1'b1;
         write_cmd = 1'b1;
         k = 0;
         for (int j = 1; j <= 20; j++)
         begin
            step(1);
            read_cmd = 1'b0;
            write_cmd = 1'b0;
            if (read_release === 1'b1 && write_release === 1'b1 && k == 0)
               k = j;
         end
         chk(17'(k), 17'(AL_EXP[i]) + 17'h1);
      end
      $display("test posted latency done");
      sr_pulse(1'b1);
      chk(17'(dll_locked), 17'h0);
      step(3);
      sr_pulse(1'b0);
      chk(17'(dll_locked), 17'h1);
      chk(17'(dll_reset_out), 17'h1);
      step(1);
      chk(17'(dll_reset_out), 17'h0);
      $display("test self refresh done");
      read_column_latency = 4'h6;
      ctrl.load_word(nom_word(3'h1) | 17'h00001);
      step(3);
      chk(17'(dll_locked), 17'h0);
      chk(17'(dll_off_latency_ok), 17'h1);
      chk(17'(termination_on), 17'h0);
      sr_pulse(1'b1);
      step(2);
      sr_pulse(1'b0);
      step(2);
      chk(17'(dll_locked), 17'h0);
      read_column_latency = 4'h7;
      step(2);
      chk(17'(dll_off_latency_ok), 17'h0);
      ctrl.enable_loop(nom_word(3'h1));
      step(3);
      chk(17'(dll_locked), 17'h1);
      chk(17'(termination_on), 17'h1);
      $display("test loop off done");
      zq_calibrate_cmd = 1'b1;
      step(1);
      zq_calibrate_cmd = 1'b0;
      step(5);
      chk(17'(impedance_calibrated), 17'h1);
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(1);
      chk(mode_register_one, 17'h00000);
      $display("test calibration and reset done");
      test_done();
   end
endmodule
`default_nettype wire
